// *** rtl/dtd_core.sv ***
// Data transfer instruction decoder and executor with its register file
`timescale 1ns/1ns
// Overview of operation
// - Bit 15 of each word is most significant
// - Register fields select registers by binary value
// - Displacement scaled by one, two or four
// - One cycle minimum; condition flag never changes
// - Fetch contention delays the data access
// - Load-use on next instruction adds a cycle
// - Sign-extended 8-bit literal into destination
// - Word load from counter plus twice displacement
// - Long load from counter plus four times
// - Indirect byte, word and long loads, byte and word sign-extended
// - Byte store after decrementing destination by one
// - Word/long store after decrementing by two/four
// - Post-increment loads advance source by size unless it is the destination
// - Byte of register zero at base plus displacement
// - Word of register zero at base plus twice
// - Long source store at base plus four times
// - Word/byte displacement loads into register zero
// - Long displacement load into destination
// - Byte store at register zero plus destination
// - No privilege checks on any transfer
module dtd_core
  import dtd_pkg::*;
#(
  parameter int NUM_REGS = 16
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Instruction from the fetch path
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_i,
  input wire logic [31:0] insn_pc_i,
  output logic insn_ready_o,
  output logic illegal_o,
  // Fetch owns the shared memory path this cycle
  input wire logic fetch_active_i,
  // Data memory bus
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Register view for the rest of the core
  input wire logic [3:0] view_sel_i,
  output logic [31:0] view_data_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] regs [NUM_REGS];
  dtd_state_e state_r;
  logic ready_r;
  logic illegal_r;
  logic [15:0] insn_r;
  logic [31:0] pc_r;
  dtd_op_s pend_r;
  logic req_r;
  logic we_r;
  logic ld_pend_r;
  logic [3:0] ld_dst_r;
  logic [31:0] view_r;

  logic take;
  logic hazard;
  logic fire;
  logic [15:0] ci;
  logic [31:0] cpc;
  dtd_op_s op;
  logic wa_en;
  logic [3:0] wa_idx;
  logic [31:0] wa_val;
  logic wb_en;
  logic [3:0] wb_idx;
  logic [31:0] wb_val;

  assign take = insn_valid_i && ready_r && (state_r == ST_DECODE);
  // Held instruction replaces the port once it has been taken
  assign ci = (state_r == ST_DECODE) ? insn_i : insn_r;
  assign cpc = (state_r == ST_DECODE) ? insn_pc_i : pc_r;

  // ****************************************************************
  // Load-use check
  // ****************************************************************
  // Compares both register fields and register zero; a literal field that
  // merely looks like the register costs one extra cycle, never a wrong value
  always_comb
  begin
    hazard = 1'b0;
    if (ld_pend_r)
    begin
      hazard = (insn_i[RN_MSB:RN_LSB] == ld_dst_r) || (insn_i[RM_MSB:RM_LSB] == ld_dst_r)
        || (ld_dst_r == IDX_ZERO);
    end
  end

  assign fire = (take && !hazard) || (state_r == ST_HAZARD);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Bit 15 is the most significant bit of the word
  always_comb
  begin
    logic [3:0] fn;
    logic [3:0] fm;
    logic [3:0] lo;
    logic [31:0] d4;
    logic [31:0] d8;
    fn = ci[RN_MSB:RN_LSB];
    fm = ci[RM_MSB:RM_LSB];
    lo = ci[LO_MSB:LO_LSB];
    d4 = {28'h0000000, lo};
    d8 = {24'h000000, ci[D8_MSB:LO_LSB]};
    op = '0;
    op.kind = K_ILL;
    op.size = SZ_LONG;
    op.dst = fn;
    // No privilege input exists; every form runs in user mode
    case (ci[OP_MSB:OP_LSB])
      OPC_IMM:
      begin
        op.kind = K_REG;
        op.data = dtd_sext(d8, SZ_BYTE);
      end
      OPC_LDW_PC:
      begin
        op.kind = K_LOAD;
        op.size = SZ_WORD;
        op.addr = cpc + (d8 << SZ_WORD);
      end
      OPC_LDL_PC:
      begin
        op.kind = K_LOAD;
        op.addr = cpc + (d8 << SZ_LONG);
      end
      OPC_GRP6:
      begin
        op.addr = regs[fm];
        op.size = dtd_size_e'(lo[1:0]);
        if (lo == SUB_MOVE)
        begin
          op.kind = K_REG;
          op.data = regs[fm];
        end
        else if (lo <= SUB_LDL)
        begin
          op.kind = K_LOAD;
        end
        else if (lo >= SUB_PIB && lo <= SUB_PIL)
        begin
          op.kind = K_LOAD;
          op.size = dtd_size_e'(lo[1:0] - 2'h0);
          op.upd_en = 1'b1;
          op.upd_idx = fm;
          op.upd_val = regs[fm] + dtd_bytes(dtd_size_e'(lo[1:0]));
        end
      end
      OPC_GRP2:
      begin
        op.data = regs[fm];
        op.size = dtd_size_e'(lo[1:0]);
        if (lo <= SUB_STL)
        begin
          op.kind = K_STORE;
          op.addr = regs[fn];
        end
        else if (lo >= SUB_PDB && lo <= SUB_PDL)
        begin
          op.kind = K_STORE;
          op.addr = regs[fn] - dtd_bytes(dtd_size_e'(lo[1:0]));
          op.upd_en = 1'b1;
          op.upd_idx = fn;
          op.upd_val = op.addr;
        end
      end
      OPC_GRP8:
      begin
        op.size = dtd_size_e'(fn[0]);
        op.addr = regs[fm] + (d4 << fn[0]);
        op.data = regs[IDX_ZERO];
        op.dst = IDX_ZERO;
        if (fn == G8_STB || fn == G8_STW)
        begin
          op.kind = K_STORE;
        end
        else if (fn == G8_LDB || fn == G8_LDW)
        begin
          op.kind = K_LOAD;
        end
      end
      OPC_STL_DSP:
      begin
        op.kind = K_STORE;
        op.addr = regs[fn] + (d4 << SZ_LONG);
        op.data = regs[fm];
      end
      OPC_LDL_DSP:
      begin
        op.kind = K_LOAD;
        op.addr = regs[fm] + (d4 << SZ_LONG);
      end
      OPC_GRP0:
      begin
        if (lo == SUB_IDX_STB)
        begin
          op.kind = K_STORE;
          op.size = SZ_BYTE;
          op.addr = regs[IDX_ZERO] + regs[fn];
          op.data = regs[fm];
        end
      end
      default:
      begin
        op.kind = K_ILL;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_DECODE;
      ready_r <= 1'b0;
      insn_r <= 16'h0000;
      pc_r <= REG_RST;
    end
    else
    begin
      case (state_r)
        ST_DECODE:
        begin
          ready_r <= 1'b1;
          if (take)
          begin
            insn_r <= insn_i;
            pc_r <= insn_pc_i;
            if (hazard)
            begin
              state_r <= ST_HAZARD;
              ready_r <= 1'b0;
            end
            else if (op.kind == K_LOAD || op.kind == K_STORE)
            begin
              state_r <= fetch_active_i ? ST_ISSUE : ST_ACCESS;
              ready_r <= 1'b0;
            end
          end
        end
        ST_HAZARD:
        begin
          if (op.kind == K_LOAD || op.kind == K_STORE)
          begin
            state_r <= fetch_active_i ? ST_ISSUE : ST_ACCESS;
          end
          else
          begin
            state_r <= ST_DECODE;
            ready_r <= 1'b1;
          end
        end
        ST_ISSUE:
        begin
          if (!fetch_active_i)
          begin
            state_r <= ST_ACCESS;
          end
        end
        ST_ACCESS:
        begin
          if (mem_ack_i)
          begin
            state_r <= ST_DECODE;
            ready_r <= 1'b1;
          end
        end
        default:
        begin
          state_r <= ST_DECODE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Data bus request
  // ****************************************************************
  // The operation is frozen at decode so later register writes cannot move it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pend_r <= '0;
      req_r <= 1'b0;
      we_r <= 1'b0;
    end
    else
    begin
      if (fire && (op.kind == K_LOAD || op.kind == K_STORE))
      begin
        pend_r <= op;
        req_r <= !fetch_active_i;
        we_r <= (op.kind == K_STORE);
      end
      else if (state_r == ST_ISSUE && !fetch_active_i)
      begin
        req_r <= 1'b1;
      end
      else if (req_r && mem_ack_i)
      begin
        req_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      illegal_r <= 1'b0;
      ld_pend_r <= 1'b0;
      ld_dst_r <= IDX_ZERO;
    end
    else
    begin
      illegal_r <= fire && (op.kind == K_ILL);
      if (req_r && mem_ack_i && pend_r.kind == K_LOAD)
      begin
        ld_pend_r <= 1'b1;
        ld_dst_r <= pend_r.dst;
      end
      else if (take)
      begin
        ld_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Port A carries results and wins over pointer updates on port B
  always_comb
  begin
    wa_en = 1'b0;
    wa_idx = op.dst;
    wa_val = op.data;
    if (req_r && mem_ack_i && pend_r.kind == K_LOAD)
    begin
      wa_en = 1'b1;
      wa_idx = pend_r.dst;
      wa_val = dtd_sext(mem_rdata_i, pend_r.size);
    end
    else if (fire && op.kind == K_REG)
    begin
      wa_en = 1'b1;
    end
    wb_en = req_r && mem_ack_i && pend_r.upd_en;
    wb_idx = pend_r.upd_idx;
    wb_val = pend_r.upd_val;
  end

  // No condition flag lives here, so none of these forms can change it
  for (genvar gi = 0; gi < NUM_REGS; gi++)
  begin : g_reg
    always_ff @(posedge clk_i)
    begin
      if (srst_i)
      begin
        regs[gi] <= REG_RST;
      end
      else if (wa_en && wa_idx == 4'(gi))
      begin
        regs[gi] <= wa_val;
      end
      else if (wb_en && wb_idx == 4'(gi))
      begin
        regs[gi] <= wb_val;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      view_r <= REG_RST;
    end
    else
    begin
      view_r <= regs[view_sel_i];
    end
  end

  assign insn_ready_o = ready_r;
  assign illegal_o = illegal_r;
  assign mem_req_o = req_r;
  assign mem_we_o = we_r;
  assign mem_size_o = pend_r.size;
  assign mem_addr_o = pend_r.addr;
  assign mem_wdata_o = pend_r.data;
  assign view_data_o = view_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_no_contend: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(mem_req_o) |-> !$past(fetch_active_i))
    else $error("data request raised while fetch held the path");

  chk_req_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    (mem_req_o && !mem_ack_i) |=> mem_req_o && $stable(mem_addr_o))
    else $error("data request dropped or moved before acknowledge");

  chk_imm_sext: assert property (@(posedge clk_i) disable iff (srst_i)
    (fire && ci[OP_MSB:OP_LSB] == OPC_IMM) |=>
    regs[$past(ci[RN_MSB:RN_LSB])] == {{24{$past(ci[D8_MSB])}}, $past(ci[D8_MSB:LO_LSB])})
    else $error("immediate not sign extended into destination");

  chk_move_copy: assert property (@(posedge clk_i) disable iff (srst_i)
    (fire && ci[OP_MSB:OP_LSB] == OPC_GRP6 && ci[LO_MSB:LO_LSB] == SUB_MOVE) |=>
    regs[$past(ci[RN_MSB:RN_LSB])] == $past(regs[ci[RM_MSB:RM_LSB]]))
    else $error("register move lost its value");

  chk_reg_one: assert property (@(posedge clk_i) disable iff (srst_i)
    (take && !hazard && op.kind == K_REG) |=> insn_ready_o && state_r == ST_DECODE)
    else $error("register form took more than one cycle");

  chk_haz_stall: assert property (@(posedge clk_i) disable iff (srst_i)
    (take && hazard) |=> !insn_ready_o ##1 state_r != ST_HAZARD)
    else $error("load-use stall missing or too long");

  chk_word_sext: assert property (@(posedge clk_i) disable iff (srst_i)
    (mem_ack_i && mem_req_o && !mem_we_o && mem_size_o == SZ_WORD) |=>
    regs[$past(pend_r.dst)] == {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i[15:0])})
    else $error("word load not sign extended");

  chk_post_inc: assert property (@(posedge clk_i) disable iff (srst_i)
    (mem_ack_i && mem_req_o && !mem_we_o && pend_r.upd_en && pend_r.upd_idx != pend_r.dst)
    |=> regs[$past(pend_r.upd_idx)] == $past(mem_addr_o) + dtd_bytes($past(pend_r.size)))
    else $error("post-increment step wrong");

  chk_pre_dec: assert property (@(posedge clk_i) disable iff (srst_i)
    (mem_ack_i && mem_req_o && mem_we_o && pend_r.upd_en) |=>
    regs[$past(pend_r.upd_idx)] == $past(mem_addr_o))
    else $error("pre-decrement pointer differs from store address");

endmodule

// *** rtl/dtd_pkg.sv ***
// Shared types and constants of the data transfer instruction decoder
package dtd_pkg;

  // ****************************************************************
  // Operand sizes, decode kinds, sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } dtd_size_e;

  typedef enum logic [2:0] {
    K_NONE  = 3'h0,
    K_REG   = 3'h1,
    K_LOAD  = 3'h2,
    K_STORE = 3'h3,
    K_ILL   = 3'h4
  } dtd_kind_e;

  typedef enum logic [1:0] {
    ST_DECODE = 2'h0,
    ST_HAZARD = 2'h1,
    ST_ISSUE  = 2'h2,
    ST_ACCESS = 2'h3
  } dtd_state_e;

  // One decoded operation, ready to execute or to put on the data bus
  typedef struct packed {
    dtd_kind_e kind;
    dtd_size_e size;
    logic [3:0] dst;
    logic [31:0] data;
    logic [31:0] addr;
    logic upd_en;
    logic [3:0] upd_idx;
    logic [31:0] upd_val;
  } dtd_op_s;

  // ****************************************************************
  // Instruction word fields
  // ****************************************************************
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int RN_MSB = 11;
  localparam int RN_LSB = 8;
  localparam int RM_MSB = 7;
  localparam int RM_LSB = 4;
  localparam int LO_MSB = 3;
  localparam int LO_LSB = 0;
  localparam int D8_MSB = 7;

  // Top nibble codes
  localparam logic [3:0] OPC_IMM = 4'hE;
  localparam logic [3:0] OPC_LDW_PC = 4'h9;
  localparam logic [3:0] OPC_LDL_PC = 4'hD;
  localparam logic [3:0] OPC_GRP6 = 4'h6;
  localparam logic [3:0] OPC_GRP2 = 4'h2;
  localparam logic [3:0] OPC_GRP0 = 4'h0;
  localparam logic [3:0] OPC_GRP8 = 4'h8;
  localparam logic [3:0] OPC_STL_DSP = 4'h1;
  localparam logic [3:0] OPC_LDL_DSP = 4'h5;

  // Low nibble codes of the register groups
  localparam logic [3:0] SUB_LDB = 4'h0;
  localparam logic [3:0] SUB_LDW = 4'h1;
  localparam logic [3:0] SUB_LDL = 4'h2;
  localparam logic [3:0] SUB_MOVE = 4'h3;
  localparam logic [3:0] SUB_PIB = 4'h4;
  localparam logic [3:0] SUB_PIL = 4'h6;
  localparam logic [3:0] SUB_STL = 4'h2;
  localparam logic [3:0] SUB_PDB = 4'h4;
  localparam logic [3:0] SUB_PDL = 4'h6;
  localparam logic [3:0] SUB_IDX_STB = 4'h4;

  // Second nibble of the top-nibble-8 group
  localparam logic [3:0] G8_STB = 4'h0;
  localparam logic [3:0] G8_STW = 4'h1;
  localparam logic [3:0] G8_LDB = 4'h4;
  localparam logic [3:0] G8_LDW = 4'h5;

  localparam logic [3:0] IDX_ZERO = 4'h0;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // Narrow loads and immediates are sign extended to 32 bits
  function automatic logic [31:0] dtd_sext(input logic [31:0] v, input dtd_size_e sz);
    case (sz)
      SZ_BYTE: dtd_sext = {{24{v[7]}}, v[7:0]};
      SZ_WORD: dtd_sext = {{16{v[15]}}, v[15:0]};
      default: dtd_sext = v;
    endcase
  endfunction

  // Byte count of an operand, also the displacement scale factor
  function automatic logic [31:0] dtd_bytes(input dtd_size_e sz);
    dtd_bytes = 32'h0000_0001 << sz;
  endfunction

endpackage

// *** test/dtd_core_bench.sv ***
// Self-checking bench of the data transfer instruction decoder
`timescale 1ns/1ns
module dtd_core_bench
  import dtd_pkg::*;
;
  logic clk, srst, insn_valid, insn_ready, illegal, fetch_act, fetch_en, view_chk;
  logic mem_req, mem_we, mem_ack, req_d, fa_d;
  logic [15:0] insn;
  logic [31:0] insn_pc, mem_addr, mem_wdata, mem_rdata, view_data, cyc, t0, seed;
  logic [1:0] mem_size, mem_wait;
  logic [3:0] view_sel;
  logic [31:0] sh [16];
  logic [66:0] exp_mem [$];
  logic [31:0] exp_view [$];
  int errors, check_count, ill_exp, ill_seen;
  logic [15:0] forms [24] = '{16'hE000, 16'h9000, 16'hD000, 16'h6003, 16'h2000, 16'h2001,
    16'h2002, 16'h6000, 16'h6001, 16'h6002, 16'h2004, 16'h2005, 16'h2006, 16'h6004, 16'h6005,
    16'h6006, 16'h8000, 16'h8100, 16'h1000, 16'h8400, 16'h8500, 16'h5000, 16'h0004, 16'hF000};

  // ****************************************************************
  // Clock, fetch contention, design and partner
  // ****************************************************************
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 32'h1;
  always @(posedge clk) fetch_act <= fetch_en && ($urandom_range(3) == 0);

  dtd_core DUT
  (
    .clk_i(clk), .srst_i(srst),
    .insn_valid_i(insn_valid), .insn_i(insn), .insn_pc_i(insn_pc),
    .insn_ready_o(insn_ready), .illegal_o(illegal), .fetch_active_i(fetch_act),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_size_o(mem_size), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .view_sel_i(view_sel), .view_data_o(view_data)
  );

  dtd_mem_model mem
  (
    .clk_i(clk), .srst_i(srst), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .wait_i(mem_wait), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ready is registered, so its level at the falling edge is what the next edge sees
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (insn_ready !== 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    // A decoder that never comes back ready is a failure, not a pause
    if (n >= 200)
    begin
      errors++;
      close_out();
    end
    @(posedge clk);
  endtask

  // Works out the expected effect of one word, then offers it until taken
  task automatic exec(input logic [15:0] w);
    logic [3:0] n, m, lo, ui;
    logic [1:0] sz;
    logic [31:0] pc, a, d, v, uv;
    logic ld, st, upd;
    n = w[11:8];
    m = w[7:4];
    lo = w[3:0];
    pc = $urandom;
    {ld, st, upd, sz, a, d, ui, uv} = '0;
    case (w[15:12])
      4'hE: sh[n] = {{24{w[7]}}, w[7:0]};
      4'h9: {ld, sz, a} = {1'b1, 2'h1, pc + (32'(w[7:0]) << 1)};
      4'hD: {ld, sz, a} = {1'b1, 2'h2, pc + (32'(w[7:0]) << 2)};
      4'h6:
        if (lo == 4'h3)
          sh[n] = sh[m];
        else
          {ld, sz, a, upd, ui, uv} = {1'b1, lo[1:0], sh[m], lo[2], m, sh[m] + (32'h1 << lo[1:0])};
      4'h2: {st, sz, d, a, upd, ui} = {1'b1, lo[1:0], sh[m],
        sh[n] - (lo[2] ? 32'h1 << lo[1:0] : 32'h0), lo[2], n};
      4'h8: {ld, st, sz, d, a, n} = {w[10], !w[10], 1'b0, w[8], sh[0],
        sh[m] + (32'(lo) << w[8]), 4'h0};
      4'h1: {st, sz, d, a} = {1'b1, 2'h2, sh[m], sh[n] + (32'(lo) << 2)};
      4'h5: {ld, sz, a} = {1'b1, 2'h2, sh[m] + (32'(lo) << 2)};
      4'h0: {st, sz, d, a} = {1'b1, 2'h0, sh[m], sh[0] + sh[n]};
      default: ill_exp++;
    endcase
    if (st)
      uv = a;
    if (ld || st)
      exp_mem.push_back({st, sz, a, d});
    if (upd)
      sh[ui] = uv;
    v = mem.pat(a);
    // Load result wins over the pointer update when both name one register
    if (ld)
      sh[n] = (sz == 2'h0) ? {{24{v[7]}}, v[7:0]} : (sz == 2'h1) ? {{16{v[15]}}, v[15:0]} : v;
    insn_valid <= 1'b1;
    insn <= w;
    insn_pc <= pc;
    mem_wait <= 2'($urandom);
    wait_ready();
  endtask

  task automatic read_all();
    insn_valid <= 1'b0;
    wait_ready();
    for (int i = 0; i < 16; i++)
    begin
      view_sel <= 4'(i);
      exp_view.push_back(sh[i]);
      @(posedge clk);
      view_chk <= 1'b1;
      @(posedge clk);
      view_chk <= 1'b0;
    end
  endtask

  function automatic logic [15:0] rand_word();
    logic [15:0] t, k;
    t = forms[$urandom_range(23)];
    k = (t[15:12] inside {4'hE, 4'h9, 4'hD, 4'h1, 4'h5}) ? 16'h0FFF :
      (t[15:12] == 4'h8) ? 16'h00FF : 16'h0FF0;
    return t | (16'($urandom) & k);
  endfunction

  task automatic mem_note(input logic [66:0] e);
    logic [31:0] k;
    k = (e[65:64] == 2'h0) ? 32'h000000FF : (e[65:64] == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
    check("address", mem_addr, e[63:32]);
    check("size", 32'(mem_size), 32'(e[65:64]));
    check("direction", 32'(mem_we), 32'(e[66]));
    if (e[66])
      check("store data", mem_wdata & k, e[31:0] & k);
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(negedge clk)
  begin
    if (view_chk === 1'b1)
      check("register view", view_data, exp_view.pop_front());
    if (illegal === 1'b1)
      ill_seen++;
    if (mem_req === 1'b1 && req_d !== 1'b1 && fa_d === 1'b1)
      check("request after fetch", 32'h1, 32'h0);
    if (mem_req === 1'b1 && mem_ack === 1'b1)
      mem_note(exp_mem.size() > 0 ? exp_mem.pop_front() : '1);
    req_d = mem_req;
    fa_d = fetch_act;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    insn_valid = 1'b0;
    insn = 16'h0000;
    insn_pc = 32'h0;
    fetch_en = 1'b0;
    fetch_act = 1'b0;
    view_sel = 4'h0;
    view_chk = 1'b0;
    mem_wait = 2'h0;
    cyc = 32'h0;
    req_d = 1'b0;
    fa_d = 1'b0;
    seed = $urandom(32'h6C690020);
    for (int i = 0; i < 16; i++)
      sh[i] = REG_RST;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    read_all();
    t0 = cyc;
    for (int i = 0; i < 16; i++)
      exec({4'hE, 4'(i), (i == 0) ? 8'h80 : 8'($urandom)});
    check("immediate cycles", cyc - t0, 32'h10);
    read_all();
    // Contention and wait states on from here, to mix stalls into every form
    fetch_en <= 1'b1;
    for (int j = 0; j < 300; j++)
    begin
      exec(rand_word());
      if (j % 30 == 29)
        read_all();
    end
    exec(16'h6226);
    exec(16'h2336);
    exec(16'hF123);
    read_all();
    check("illegal pulses", 32'(ill_seen), 32'(ill_exp));
    check("unanswered accesses", 32'(exp_mem.size()), 32'h0);
    close_out();
  end

  initial
  begin
    #400000;
    errors++;
    close_out();
  end
endmodule

// *** test/dtd_mem_model.sv ***
// Data memory partner model with programmable wait states
`timescale 1ns/1ns
module dtd_mem_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Data bus from the decoder
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [1:0] wait_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [1:0] cnt_r;

  // Content is a fixed function of the address, so stores need no storage
  function automatic logic [31:0] pat(input logic [31:0] a);
    return (a * 32'h9E3779B1) ^ 32'h0F0F8181;
  endfunction

  always_ff @(posedge clk_i)
    if (srst_i || !mem_req_i || mem_ack_o)
    begin
      mem_ack_o <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (cnt_r == wait_i)
      mem_ack_o <= 1'b1;
    else
      cnt_r <= cnt_r + 2'h1;

  // Outside the ack cycle the lines show the inverse, so stale data never matches
  assign mem_rdata_o = mem_ack_o ? pat(mem_addr_i) : ~pat(mem_addr_i);
endmodule
